//--- src/console_uart.sv
/*
  Console UART control block: control register, holding and receive
  registers, transmitter, receiver, break, loop-back, echo and infra-red.
  Assumes a single-cycle register port on core_clk; pins are asynchronous.
*/
// Our own choice: the address-and-strobe port.
// Overview of operation
// - transmit mode 00 disables, 01 lets cpu write holding register
// - receive mode 00 disables, 01 lets cpu read receive register
// - send-break bit holds the transmit pin low continuously unless loop-back is on
// - bit 5 picks half-rate core clock or external uart clock
// - loop-back holds pin high and routes transmit data to receiver
// - parity: none, odd, forced one, forced zero on both directions
// - bit 11 selects one or two stop bits
// - word length field gives five to eight data bits
// - infra-red mode sends each zero as a 3/16 bit pulse
// - infra-red receiver takes a short pulse as a zero bit
// - flow enable compares received characters with the match character
// - echo forwards received line to transmit pin, holding data waits
// - holding register moves into shifter then goes out serially
// - receiver shifts in and transfers full character to receive register
// - low level at a stop bit raises a framing error
`timescale 1ns/100ps
`default_nettype none
module console_uart
  import console_uart_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic external_uart_clock,
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin
);
  import console_uart_pkg::*;

  // ==========================================================
  // registers and decode
  logic [31:0] uart_control;
  logic [15:0] baud_divisor;
  logic [7:0] match_char;
  logic [7:0] transmit_holding_register;
  logic [7:0] receive_data_register;
  logic hold_full, rx_valid, frame_err, parity_err, overrun_err, match_seen;

  wire [1:0] transmit_mode_field = uart_control[TRANSMIT_MODE_FIELD_LSB +: 2];
  wire [1:0] receive_mode_field = uart_control[RECEIVE_MODE_FIELD_LSB +: 2];
  wire send_break_bit = uart_control[BREAK_BIT];
  wire baud_clock_select = uart_control[CLKSEL_BIT];
  wire loopback_enable = uart_control[LOOP_BIT];
  wire [2:0] parity_select = uart_control[PARITY_LSB +: 3];
  wire stop_bit_count = uart_control[STOP_BIT];
  wire [1:0] word_length_field = uart_control[WLEN_LSB +: 2];
  wire ir_mode = uart_control[IR_BIT];
  wire soft_flow_enable = uart_control[FLOW_BIT];
  wire echo_enable = uart_control[ECHO_BIT];

  wire tx_enabled = transmit_mode_field == MODE_CPU;
  wire rx_enabled = receive_mode_field == MODE_CPU;
  wire [3:0] word_bits = WORD_BASE + {2'b00, word_length_field};
  wire parity_on = parity_select[2];
  wire parity_forced = parity_select[1];
  wire parity_force_val = ~parity_select[0];

  wire wr_control = reg_write && reg_addr == UART_CONTROL_ADDR;
  wire wr_status = reg_write && reg_addr == UART_STATUS_ADDR;
  wire wr_holding = reg_write && reg_addr == HOLDING_ADDR && tx_enabled;
  wire wr_divisor = reg_write && reg_addr == BAUD_DIVISOR_ADDR;
  wire wr_match = reg_write && reg_addr == MATCH_CHAR_ADDR;
  wire rd_receive = reg_read && reg_addr == RECEIVE_ADDR && rx_enabled;

  // ==========================================================
  // pin synchronisers and baud source
  logic [1:0] ext_sync, rx_sync;
  logic ext_prev, half_phase;
  wire ext_rise = ext_sync[1] && !ext_prev;
  wire src_tick = baud_clock_select ? ext_rise : half_phase;
  wire os_tick;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync <= 2'b00;
      rx_sync <= 2'b11;
      ext_prev <= 1'b0;
      half_phase <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], external_uart_clock};
      rx_sync <= {rx_sync[0], serial_receive_pin};
      ext_prev <= ext_sync[1];
      half_phase <= ~half_phase;
    end
  end

  baud_tick_gen baud_gen (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .src_tick(src_tick),
    .divisor(baud_divisor),
    .os_tick(os_tick)
  );

  // ==========================================================
  // transmitter
  tx_state_type tx_state, next_tx_state;
  logic [7:0] tx_shift;
  logic [3:0] tx_sub, tx_count;
  logic tx_parity;
  wire tx_end = os_tick && tx_sub == TICK_LAST;
  wire tx_load = tx_state == TX_IDLE && hold_full && !echo_enable && os_tick;
  wire tx_idle = tx_state == TX_IDLE && !hold_full;
  wire [7:0] tx_mask = 8'hFF >> (WORD_MAX - word_bits);
  wire odd_fill = ~^(transmit_holding_register & tx_mask);

  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE: if (tx_load) next_tx_state = TX_START;
      TX_START: if (tx_end) next_tx_state = TX_DATA;
      TX_DATA: if (tx_end && tx_count == word_bits - 4'h1)
        next_tx_state = parity_on ? TX_PAR : TX_STOP;
      TX_PAR: if (tx_end) next_tx_state = TX_STOP;
      TX_STOP: if (tx_end && tx_count == {3'b000, stop_bit_count}) next_tx_state = TX_IDLE;
      default: next_tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= TX_IDLE;
      tx_shift <= 8'h00;
      tx_sub <= 4'h0;
      tx_count <= 4'h0;
      tx_parity <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      if (tx_load) begin
        tx_shift <= transmit_holding_register;
        tx_parity <= parity_forced ? parity_force_val : odd_fill;
        tx_sub <= 4'h0;
      end else if (os_tick) begin
        tx_sub <= tx_sub + 4'h1;
      end
      if (tx_end && tx_state == TX_DATA) tx_shift <= {1'b0, tx_shift[7:1]};
      if (tx_end) tx_count <= next_tx_state != tx_state ? 4'h0 : tx_count + 4'h1;
      else if (tx_load) tx_count <= 4'h0;
    end
  end

  // current bit level before infra-red shaping
  wire tx_bit = tx_state == TX_START ? 1'b0 :
                tx_state == TX_DATA ? tx_shift[0] :
                tx_state == TX_PAR ? tx_parity : 1'b1;
  // infra-red idles low and marks a zero by a short high pulse
  wire tx_ir_line = tx_state != TX_IDLE && !tx_bit && tx_sub < IR_PULSE;
  wire tx_line = ir_mode ? tx_ir_line : tx_bit;
  logic next_pin;
  always_comb begin
    if (loopback_enable) next_pin = 1'b1;
    else if (send_break_bit) next_pin = 1'b0;
    else if (echo_enable) next_pin = rx_sync[1];
    else next_pin = tx_line;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) serial_transmit_pin <= 1'b1;
    else serial_transmit_pin <= next_pin;
  end

  // ==========================================================
  // receiver
  rx_state_type rx_state, next_rx_state;
  logic [7:0] rx_shift;
  logic [3:0] rx_sub, rx_count;
  logic rx_seen, rx_mid, rx_par_bad;
  // loop-back feeds the internal transmit line straight in
  wire rx_in = loopback_enable ? tx_line : rx_sync[1];
  wire rx_zero = ir_mode ? rx_in : ~rx_in;
  wire rx_end = os_tick && rx_sub == TICK_LAST;
  // only early pulses count: the next bit's pulse may start before this window ends
  wire rx_bit = ir_mode ? ~rx_seen : rx_mid;
  wire rx_begin = rx_state == RX_IDLE && rx_enabled && os_tick && rx_zero;
  wire rx_last_stop = rx_state == RX_STOP && rx_end && rx_count == {3'b000, stop_bit_count};
  wire rx_stop_low = rx_state == RX_STOP && rx_end && !rx_bit;
  wire rx_done = rx_last_stop && !rx_stop_low;
  wire [7:0] rx_char = rx_shift >> (WORD_MAX - word_bits);
  wire rx_odd = ~^rx_char;
  wire rx_par_want = parity_forced ? parity_force_val : rx_odd;

  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      RX_IDLE: if (rx_begin) next_rx_state = RX_START;
      RX_START: if (rx_end) next_rx_state = rx_bit ? RX_IDLE : RX_DATA;
      RX_DATA: if (rx_end && rx_count == word_bits - 4'h1)
        next_rx_state = parity_on ? RX_PAR : RX_STOP;
      RX_PAR: if (rx_end) next_rx_state = RX_STOP;
      RX_STOP: if (rx_last_stop || rx_stop_low) next_rx_state = RX_IDLE;
      default: next_rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= RX_IDLE;
      rx_shift <= 8'h00;
      rx_sub <= 4'h0;
      rx_count <= 4'h0;
      rx_seen <= 1'b0;
      rx_mid <= 1'b1;
      rx_par_bad <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      if (rx_begin || rx_end) rx_seen <= 1'b0;
      else if (rx_zero && rx_sub < TICK_MID) rx_seen <= 1'b1;
      if (rx_begin) rx_sub <= 4'h0;
      else if (os_tick) rx_sub <= rx_sub + 4'h1;
      if (os_tick && rx_sub == TICK_MID) rx_mid <= ~rx_zero;
      if (rx_begin) begin
        rx_count <= 4'h0;
        rx_par_bad <= 1'b0;
      end else if (rx_end) begin
        rx_count <= next_rx_state != rx_state ? 4'h0 : rx_count + 4'h1;
      end
      if (rx_end && rx_state == RX_DATA) rx_shift <= {rx_bit, rx_shift[7:1]};
      if (rx_end && rx_state == RX_PAR) rx_par_bad <= rx_bit != rx_par_want;
    end
  end

  // ==========================================================
  // register writes and sticky status
  wire clr_frame = wr_status && reg_wdata[ST_FRAME];
  wire clr_parity = wr_status && reg_wdata[ST_PARITY];
  wire clr_overrun = wr_status && reg_wdata[ST_OVERRUN];
  wire clr_match = wr_status && reg_wdata[ST_MATCH];
  wire rx_match = rx_done && soft_flow_enable && rx_char == match_char;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      uart_control <= CONTROL_RESET;
      baud_divisor <= DIVISOR_RESET;
      match_char <= MATCH_RESET;
      transmit_holding_register <= 8'h00;
      receive_data_register <= 8'h00;
      hold_full <= 1'b0;
      rx_valid <= 1'b0;
      frame_err <= 1'b0;
      parity_err <= 1'b0;
      overrun_err <= 1'b0;
      match_seen <= 1'b0;
    end else begin
      if (wr_control) uart_control <= reg_wdata & CONTROL_WRITABLE;
      if (wr_divisor) baud_divisor <= reg_wdata[15:0];
      if (wr_match) match_char <= reg_wdata[7:0];
      if (wr_holding) transmit_holding_register <= reg_wdata[7:0];
      // a new write wins over the transfer into the shifter
      if (wr_holding) hold_full <= 1'b1;
      else if (tx_load) hold_full <= 1'b0;
      if (rx_done) receive_data_register <= rx_char;
      if (rx_done) rx_valid <= 1'b1;
      else if (rd_receive) rx_valid <= 1'b0;
      if (rx_stop_low) frame_err <= 1'b1;
      else if (clr_frame) frame_err <= 1'b0;
      if (rx_done && rx_par_bad && parity_on) parity_err <= 1'b1;
      else if (clr_parity) parity_err <= 1'b0;
      if (rx_done && rx_valid && !rd_receive) overrun_err <= 1'b1;
      else if (clr_overrun) overrun_err <= 1'b0;
      if (rx_match) match_seen <= 1'b1;
      else if (clr_match) match_seen <= 1'b0;
    end
  end

  // ==========================================================
  // read path: data only in the cycle after the read strobe
  logic [31:0] status_word, read_mux;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_RX_VALID] = rx_valid;
    status_word[ST_FRAME] = frame_err;
    status_word[ST_PARITY] = parity_err;
    status_word[ST_OVERRUN] = overrun_err;
    status_word[ST_MATCH] = match_seen;
    status_word[ST_RX_IDLE] = rx_state == RX_IDLE;
    status_word[ST_TX_IDLE] = tx_idle;
    status_word[ST_HOLD_EMPTY] = !hold_full;
    case (reg_addr)
      UART_CONTROL_ADDR: read_mux = uart_control;
      UART_STATUS_ADDR: read_mux = status_word;
      RECEIVE_ADDR: read_mux = rx_enabled ? {24'h000000, receive_data_register} : 32'h0000_0000;
      BAUD_DIVISOR_ADDR: read_mux = {16'h0000, baud_divisor};
      MATCH_CHAR_ADDR: read_mux = {24'h000000, match_char};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) reg_rdata <= 32'h0000_0000;
    else reg_rdata <= reg_read ? read_mux : 32'h0000_0000;
  end

  // ==========================================================
  // checks
  loop_pin_high_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(loopback_enable) |-> serial_transmit_pin)
    else $error("loop-back did not hold the pin high");
  break_pin_low_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(send_break_bit && !loopback_enable) |-> !serial_transmit_pin)
    else $error("break did not hold the pin low");
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_read && reg_addr == UART_CONTROL_ADDR |=> (reg_rdata & ~CONTROL_WRITABLE) == 32'h0)
    else $error("reserved control bits read non-zero");
  holding_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_write && reg_addr == HOLDING_ADDR && !tx_enabled && !hold_full |=> !hold_full)
    else $error("holding register filled while transmit disabled");
  rx_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    rx_state == RX_IDLE && !rx_enabled |=> rx_state == RX_IDLE)
    else $error("receiver started while reception disabled");
  frame_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    rx_stop_low |=> frame_err && rx_state == RX_IDLE)
    else $error("low stop bit did not flag a framing error");
  shifter_load_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    tx_load && !wr_holding |=> tx_state == TX_START && !hold_full ##1 tx_state == TX_START)
    else $error("holding data not moved into the shifter");
  rx_deliver_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    rx_done |=> rx_valid && receive_data_register == $past(rx_char))
    else $error("received character not delivered");
  idle_high_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(tx_state == TX_IDLE && uart_control[ECHO_BIT:BREAK_BIT] == 27'h0) |-> serial_transmit_pin)
    else $error("line not idle high");
  ir_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ir_mode && tx_state == TX_START && tx_sub >= IR_PULSE && uart_control[LOOP_BIT:BREAK_BIT] == 4'h0
      && !echo_enable |=> !serial_transmit_pin)
    else $error("infra-red pulse longer than 3/16 bit");
  echo_follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    echo_enable && !loopback_enable && !send_break_bit |=> serial_transmit_pin == $past(rx_sync[1]))
    else $error("echo did not forward the received line");
endmodule : console_uart
`default_nettype wire

//--- src/console_uart_pkg.sv
/*
  Shared constants of the console UART control block: register map,
  control and status field positions, reset values and bit timing.
  Assumes a 32-bit register port whose addresses are full byte addresses.
*/
package console_uart_pkg;
  // ==========================================================
  // register map
  localparam logic [31:0] UART_CONTROL_ADDR = 32'hF006_0000;
  localparam logic [31:0] UART_STATUS_ADDR = 32'hF006_0004;
  localparam logic [31:0] HOLDING_ADDR = 32'hF006_000C;
  localparam logic [31:0] RECEIVE_ADDR = 32'hF006_0010;
  localparam logic [31:0] BAUD_DIVISOR_ADDR = 32'hF006_0014;
  localparam logic [31:0] MATCH_CHAR_ADDR = 32'hF006_0018;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_WRITABLE = 32'h6000_7FBF;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  localparam logic [7:0] MATCH_RESET = 8'h00;
  // ==========================================================
  // control fields
  localparam int TRANSMIT_MODE_FIELD_LSB = 0;
  localparam int RECEIVE_MODE_FIELD_LSB = 2;
  localparam int BREAK_BIT = 4;
  localparam int CLKSEL_BIT = 5;
  localparam int LOOP_BIT = 7;
  localparam int PARITY_LSB = 8;
  localparam int STOP_BIT = 11;
  localparam int WLEN_LSB = 12;
  localparam int IR_BIT = 14;
  localparam int FLOW_BIT = 29;
  localparam int ECHO_BIT = 30;
  localparam logic [1:0] MODE_CPU = 2'h1;
  // ==========================================================
  // status fields
  localparam int ST_RX_VALID = 0;
  localparam int ST_FRAME = 2;
  localparam int ST_PARITY = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_MATCH = 5;
  localparam int ST_RX_IDLE = 11;
  localparam int ST_TX_IDLE = 17;
  localparam int ST_HOLD_EMPTY = 18;
  // ==========================================================
  // bit timing in oversample ticks, word lengths in data bits
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [3:0] WORD_BASE = 4'h5;
  localparam logic [3:0] WORD_MAX = 4'h8;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_type;
endpackage : console_uart_pkg

//--- src/baud_tick_gen.sv
/*
  Oversample tick generator: counts source ticks and pulses once every
  divisor+1 of them. Assumes src_tick is a one-cycle pulse on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module baud_tick_gen (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic src_tick,
  input wire logic [15:0] divisor,
  output logic os_tick
);
  logic [15:0] count;
  wire wrap = src_tick && (count >= divisor);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 16'h0000;
      os_tick <= 1'b0;
    end else begin
      os_tick <= wrap;
      if (wrap) count <= 16'h0000;
      else if (src_tick) count <= count + 16'h0001;
    end
  end
endmodule : baud_tick_gen
`default_nettype wire

//--- verification/serial_peer.sv
/*
  Behavioural far-side serial terminal: captures frames from the device's
  transmit pin and sends frames to its receive pin.
  Assumes idle-high lines; the bit time is learnt from a captured start bit.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  input wire logic line_in,
  output logic line_out
);
  // ==========================================================
  // frame capture and send
  realtime bit_ns = 320.0;
  initial line_out = 1'b1;
  // start width is measured, so captured data must have bit 0 set
  task automatic capture(input int n, input logic has_par, output logic [7:0] v,
      output logic par, output logic [1:0] stops);
    realtime t0;
    v = 8'h00;
    par = 1'b0;
    @(negedge line_in);
    t0 = $realtime;
    @(posedge line_in);
    bit_ns = $realtime - t0;
    #(bit_ns / 2.0);
    for (int i = 0; i < n; i++) begin
      v[i] = line_in;
      #(bit_ns);
    end
    if (has_par) begin
      par = line_in;
      #(bit_ns);
    end
    stops[0] = line_in;
    #(bit_ns);
    stops[1] = line_in;
  endtask : capture
  task automatic send(input logic [7:0] v, input int n, input logic has_par,
      input logic par, input logic stop_lvl);
    line_out = 1'b0;
    #(bit_ns);
    for (int i = 0; i < n; i++) begin
      line_out = v[i];
      #(bit_ns);
    end
    if (has_par) begin
      line_out = par;
      #(bit_ns);
    end
    line_out = stop_lvl;
    #(bit_ns);
    line_out = 1'b1;
    #(2.0 * bit_ns);
  endtask : send
endmodule : serial_peer
`default_nettype wire

//--- verification/console_uart_tb.sv
/*
  Self-checking bench for console_uart: register port tasks and serial
  frames through serial_peer. Assumes the package map and a 5 ns clock.
*/
`timescale 1ns/100ps
`default_nettype none
module console_uart_tb;
  import console_uart_pkg::*;
  logic core_clk = 0, rst_b = 0, reg_write = 0, reg_read = 0, ext_clk = 0;
  logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, rd_v;
  wire tx_pin, rx_pin;
  int bad_count = 0, checks = 0, cycles = 0, miss;
  logic [7:0] d, got, m8;
  logic p;
  logic [1:0] st;
  logic [2:0] pc [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
  always #2.5 core_clk = ~core_clk;
  always #20 ext_clk = ~ext_clk;
  console_uart dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .external_uart_clock(ext_clk),
    .serial_receive_pin(rx_pin), .serial_transmit_pin(tx_pin));
  serial_peer peer (.line_in(tx_pin), .line_out(rx_pin));
  // ==========================================================
  // helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask : rd
  task watch(input int n, input logic lvl);
    miss = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (tx_pin !== lvl) miss++;
    end
  endtask : watch
  // one mode value serves both directions
  function logic [31:0] ctl(logic [1:0] m, logic [2:0] pcode, logic stop, logic [1:0] wl,
      logic [31:0] extra);
    return {18'h0, wl, stop, pcode, 4'h0, m, m} | extra;
  endfunction : ctl
  function logic expar(logic [2:0] c, logic [7:0] v);
    return (c == 3'h4) ? ~^v : (c == 3'h6);
  endfunction : expar
  task conclude;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end
  // ==========================================================
  // main sequence; modes only change between frames
  initial begin
    d = 8'($urandom(32'h5C8E3110));
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(UART_CONTROL_ADDR, rd_v);
    check(rd_v, 32'h0000_0000);
    rd(UART_STATUS_ADDR, rd_v);
    check(rd_v, 32'h0006_0800);
    wr(UART_CONTROL_ADDR, 32'hFFFF_FFFF);
    rd(UART_CONTROL_ADDR, rd_v);
    check(rd_v, 32'h6000_7FBF);
    rd(32'hF006_0008, rd_v);
    check(rd_v, 32'h0000_0000);
    wr(UART_CONTROL_ADDR, 32'h0000_0000);
    wr(HOLDING_ADDR, 32'h0000_0055);
    watch(400, 1'b1);
    check(miss, 0);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom) | 8'h01;
      m8 = 8'hFF >> (3 - i % 4);
      wr(UART_CONTROL_ADDR, ctl(2'h1, pc[i % 4], i[2], i[1:0], (i == 0) ? 32'h20 : 32'h0));
      fork
        peer.capture(5 + i % 4, pc[i % 4][2], got, p, st);
        begin
          wr(HOLDING_ADDR, {24'h0, d});
          do rd(UART_STATUS_ADDR, rd_v); while (rd_v[ST_HOLD_EMPTY] !== 1'b1);
          wr(HOLDING_ADDR, {24'h0, d});
        end
      join
      check(got, d & m8);
      if (pc[i % 4][2]) check(p, expar(pc[i % 4], d & m8));
      check(st, {i[2], 1'b1});
      if (i == 0) check($rtoi((peer.bit_ns + 20.0) / 40.0), 16);
      do rd(UART_STATUS_ADDR, rd_v); while (rd_v[ST_TX_IDLE] !== 1'b1);
    end
    for (int j = 0; j < 4; j++) begin
      d = 8'($urandom) & (8'hFF >> (3 - j));
      wr(MATCH_CHAR_ADDR, {24'h0, d});
      wr(UART_CONTROL_ADDR, ctl(2'h1, pc[j], j[0], j[1:0], {2'b00, j[0], 29'h0}));
      peer.send(d, 5 + j, pc[j][2], expar(pc[j], d), 1'b1);
      rd(UART_STATUS_ADDR, rd_v);
      check(rd_v[5:0], {j[0], 5'h01});
      rd(RECEIVE_ADDR, rd_v);
      check(rd_v, {24'h0, d});
      wr(UART_STATUS_ADDR, 32'h0000_003C);
    end
    wr(UART_CONTROL_ADDR, ctl(2'h1, 3'h0, 1'b0, 2'h3, 32'h0));
    peer.send(8'hA5, 8, 1'b0, 1'b0, 1'b0);
    rd(UART_STATUS_ADDR, rd_v);
    check(rd_v[2:0], 3'h4);
    wr(UART_STATUS_ADDR, 32'h0000_003C);
    wr(UART_CONTROL_ADDR, ctl(2'h1, 3'h6, 1'b0, 2'h3, 32'h0));
    peer.send(8'h5A, 8, 1'b1, 1'b0, 1'b1);
    rd(UART_STATUS_ADDR, rd_v);
    check(rd_v[3:0], 4'h9);
    rd(RECEIVE_ADDR, rd_v);
    check(rd_v, 32'h0000_005A);
    wr(UART_STATUS_ADDR, 32'h0000_003C);
    wr(UART_CONTROL_ADDR, ctl(2'h0, 3'h0, 1'b0, 2'h3, 32'h0));
    peer.send(8'h3C, 8, 1'b0, 1'b0, 1'b1);
    rd(RECEIVE_ADDR, rd_v);
    check(rd_v, 32'h0000_0000);
    wr(UART_CONTROL_ADDR, ctl(2'h1, 3'h0, 1'b0, 2'h3, 32'h4000_0000));
    wr(HOLDING_ADDR, 32'h0000_000F);
    d = 8'($urandom) | 8'h01;
    fork
      peer.send(d, 8, 1'b0, 1'b0, 1'b1);
      peer.capture(8, 1'b0, got, p, st);
    join
    check(got, d);
    rd(RECEIVE_ADDR, rd_v);
    check(rd_v, {24'h0, d});
    // the held character goes out internally once echo is dropped
    wr(UART_CONTROL_ADDR, ctl(2'h1, 3'h0, 1'b0, 2'h3, 32'h80));
    watch(1200, 1'b1);
    check(miss, 0);
    rd(RECEIVE_ADDR, rd_v);
    check(rd_v, 32'h0000_000F);
    // infra-red: the pin idles low and each zero bit is a 3/16 bit high pulse
    wr(UART_CONTROL_ADDR, ctl(2'h0, 3'h0, 1'b0, 2'h3, 32'h4001));
    d = 8'($urandom);
    wr(HOLDING_ADDR, {24'h0, d});
    watch(500, 1'b0);
    check(miss, (9 - $countones(d)) * 3 * $rtoi(peer.bit_ns / 5.0) / 16);
    wr(UART_CONTROL_ADDR, ctl(2'h1, 3'h4, 1'b0, 2'h3, 32'h4080));
    wr(HOLDING_ADDR, {24'h0, d});
    watch(600, 1'b1);
    check(miss, 0);
    rd(RECEIVE_ADDR, rd_v);
    check(rd_v, {24'h0, d});
    wr(UART_CONTROL_ADDR, ctl(2'h1, 3'h0, 1'b0, 2'h3, 32'h10));
    repeat (4) @(posedge core_clk);
    watch(12 * $rtoi(peer.bit_ns / 5.0), 1'b0);
    check(miss, 0);
    wr(UART_CONTROL_ADDR, 32'h0000_0000);
    conclude();
  end
endmodule : console_uart_tb
`default_nettype wire
